// ---- sim/lpm_testbench.sv ----
// self-checking testbench for the low-power-mode power configuration block
`timescale 1ns/1ps

module testbench
    import lpm_pkg::*;
;
    // ==================================================================
    // clock, reset and stimulus
    logic        i_mclk;
    logic        i_nrst;
    logic [31:0] i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        i_lowpower_enter;
    logic        i_wakeup;
    logic        i_wdt_lock;
    logic        i_irc_stop_point;
    lpm_analog_t o_power_off;
    logic        o_low_power;
    int          bad_count;
    int          checks;

    lpm_power_config dut (
        .i_mclk           (i_mclk),
        .i_nrst           (i_nrst),
        .i_addr           (i_addr),
        .i_wdata          (i_wdata),
        .i_wr             (i_wr),
        .i_rd             (i_rd),
        .o_rdata          (o_rdata),
        .i_lowpower_enter (i_lowpower_enter),
        .i_wakeup         (i_wakeup),
        .i_wdt_lock       (i_wdt_lock),
        .i_irc_stop_point (i_irc_stop_point),
        .o_power_off      (o_power_off),
        .o_low_power      (o_low_power)
    );

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    // ==================================================================
    // bus cycles and comparisons
    task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp8(input string what, input logic [7:0] exp);
        cmp32(what, {24'h00_0000, exp}, {24'h00_0000, o_power_off});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd_check(input string what, input logic [31:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1;
        // read data stand only in the cycle after the read strobe
        cmp32(what, exp, o_rdata);
    endtask

    // write then read back with no gap between the strobes
    task automatic wr_rd(input string what, input logic [31:0] a, input logic [31:0] d,
                         input logic [31:0] exp);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
        i_rd    <= 1'b1;
        @(posedge i_mclk);
        i_rd    <= 1'b0;
        #1;
        cmp32(what, exp, o_rdata);
    endtask

    // one-cycle pulse on a mode input, outputs judged one cycle later
    task automatic pulse(input logic enter, input logic [7:0] exp_off, input logic exp_low);
        @(posedge i_mclk);
        i_lowpower_enter <= enter;
        i_wakeup         <= ~enter;
        @(posedge i_mclk);
        i_lowpower_enter <= 1'b0;
        i_wakeup         <= 1'b0;
        #1;
        cmp8("power_off", exp_off);
        cmp32("low_power", {31'h0, exp_low}, {31'h0, o_low_power});
    endtask

    task automatic wrap_up;
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==================================================================
    // scenarios
    task automatic sc_reset_values;
        cmp8("power_off", 8'hF0);
        rd_check("sleep", LPM_SLEEP_ADDR, 32'h0000_FFFF);
        rd_check("wake", LPM_WAKE_ADDR, 32'h0000_6DF0);
        rd_check("live", LPM_LIVE_ADDR, 32'h0000_6DF0);
        rd_check("unmapped", 32'h4004_8240, 32'h0000_0000);
    endtask

    task automatic sc_enter_and_wake;
        wr_rd("wake", LPM_WAKE_ADDR, 32'h0000_6D5A, 32'h0000_6D5A);
        wr_rd("sleep", LPM_SLEEP_ADDR, 32'h0000_FFB7, 32'h0000_FFB7);
        pulse(1'b1, 8'hB7, 1'b1);
        // live writes are refused while in low power
        wr_rd("live", LPM_LIVE_ADDR, 32'h0000_6D00, 32'h0000_6DB7);
        pulse(1'b1, 8'hB7, 1'b1);
        pulse(1'b0, 8'h5A, 1'b0);
    endtask

    task automatic sc_lock;
        @(posedge i_mclk);
        i_wdt_lock <= 1'b1;
        wr_rd("sleep", LPM_SLEEP_ADDR, 32'h0000_FFFF, 32'h0000_FFBF);
        wr_rd("wake", LPM_WAKE_ADDR, 32'h0000_6DFF, 32'h0000_6DBF);
        wr(LPM_LIVE_ADDR, 32'h0000_6D40);
        cmp8("power_off", 8'h00);
        pulse(1'b1, 8'hBF, 1'b1);
        pulse(1'b0, 8'hBF, 1'b0);
        @(posedge i_mclk);
        i_wdt_lock <= 1'b0;
    endtask

    task automatic sc_irc_stop;
        int n;
        wr(LPM_LIVE_ADDR, 32'h0000_6D00);
        cmp8("power_off", 8'h00);
        wr(LPM_LIVE_ADDR, 32'h0000_6D02);
        repeat (3) @(posedge i_mclk);
        #1;
        cmp8("power_off", 8'h00);
        @(posedge i_mclk);
        i_irc_stop_point <= 1'b1;
        n = 0;
        // oscillator power-down waits for a clean stop point
        while (o_power_off !== 8'h02 && n < 4) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        cmp8("power_off", 8'h02);
        i_irc_stop_point <= 1'b0;
    endtask

    // ==================================================================
    // main sequence
    initial begin
        bad_count        = 0;
        checks           = 0;
        i_nrst           = 1'b0;
        i_addr           = 32'h0000_0000;
        i_wdata          = 32'h0000_0000;
        i_wr             = 1'b0;
        i_rd             = 1'b0;
        i_lowpower_enter = 1'b0;
        i_wakeup         = 1'b0;
        i_wdt_lock       = 1'b0;
        i_irc_stop_point = 1'b0;
        repeat (12) @(posedge i_mclk);
        i_nrst <= 1'b1;
        #1;
        sc_reset_values();
        sc_enter_and_wake();
        sc_lock();
        sc_irc_stop();
        wrap_up();
    end
endmodule

// ---- verilog/lpm_pkg.sv ----
// package for the low-power-mode power configuration block: map, fields, reset values
package lpm_pkg;

    // ==================================================================
    // register byte addresses
    localparam logic [31:0] LPM_SLEEP_ADDR = 32'h4004_8230;
    localparam logic [31:0] LPM_WAKE_ADDR  = 32'h4004_8234;
    localparam logic [31:0] LPM_LIVE_ADDR  = 32'h4004_8238;

    // ==================================================================
    // analog block field positions, shared by all three words
    localparam int LPM_IRCOUT_BIT = 0;
    localparam int LPM_IRC_BIT    = 1;
    localparam int LPM_FLASH_BIT  = 2;
    localparam int LPM_BOD_BIT    = 3;
    localparam int LPM_ADC_BIT    = 4;
    localparam int LPM_SYSOSC_BIT = 5;
    localparam int LPM_WDT_BIT    = 6;
    localparam int LPM_PLL_BIT    = 7;

    // ==================================================================
    // widths and reset values
    localparam int          LPM_SLEEP_W     = 16;
    localparam int          LPM_CFG_W       = 15;
    localparam logic [15:0] LPM_SLEEP_RSVD  = 16'hFFB7;
    localparam logic        LPM_SLEEP_BOD_R = 1'b1;
    localparam logic        LPM_SLEEP_WDT_R = 1'b1;
    localparam logic [14:0] LPM_CFG_RESET   = 15'h6DF0;
    localparam logic [7:0]  LPM_ALL_OFF     = 8'hFF;

    // ==================================================================
    // analog power-down bits, 1 = powered down
    typedef struct packed {
        logic system_pll_off;
        logic watchdog_osc_off;
        logic crystal_osc_off;
        logic converter_off;
        logic brownout_off;
        logic flash_off;
        logic internal_osc_off;
        logic internal_osc_output_off;
    } lpm_analog_t;

    typedef enum logic [0:0] {
        LPM_RUN,
        LPM_LOW
    } lpm_state_t;

endpackage

// ---- verilog/lpm_power_config.sv ----
// low-power-mode power configuration: sleep word, wake-up word and live power control
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// [RL1] on low-power entry copy sleep brown-out and watchdog bits into live control
// [RL2] on low-power entry force every analog block off except brown-out and watchdog oscillator, which take their sleep bits
// [RL3] brown-out and watchdog oscillator stay powered when their sleep bit is 0
// [RL4] sleep brown-out bit 3: 0 powered, 1 off, resets to 1
// [RL5] sleep watchdog bit 6: 0 powered, 1 off, resets to 1
// [RL6] watchdog lock overwrites sleep watchdog power-down value to powered
// [RL7] watchdog lock makes any watchdog power-down setting ineffective
// [RL8] on wake-up apply the wake-up word to every analog block
// [RL9] wake-up bits 0 to 3 select oscillator output, oscillator, flash, brown-out; reset 0
// [RL10] wake-up bits 4 to 6 select converter, crystal, watchdog oscillator; reset 1
// [RL11] wake-up bit 7 selects system pll on wake-up; reset 1
// [RL12] software writes 0b1101 into wake-up bits 11 to 8
// [RL13] software writes 0b110 into wake-up bits 14 to 12
// [RL14] live writes act at once; oscillator power-down waits for clean stop point; here live writes are ignored while in low-power mode
// [RL15] software keeps reserved sleep bits at all ones via read-modify-write
module lpm_power_config
    import lpm_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_nrst,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [31:0]            o_rdata,
    // mode sequencing
    input  wire logic              i_lowpower_enter,
    input  wire logic              i_wakeup,
    input  wire logic              i_wdt_lock,
    input  wire logic              i_irc_stop_point,
    // power control
    output lpm_analog_t            o_power_off,
    output logic                   o_low_power
);

    // ==================================================================
    // parameter check
    generate
        if (ADDR_W != 32) begin : g_bad_addr
            $error("lpm_power_config: ADDR_W must be 32");
        end
    endgenerate

    // ==================================================================
    // state
    logic                 sleep_bod;
    logic                 sleep_wdt;
    logic [LPM_CFG_W-1:0] wake_cfg;
    logic [LPM_CFG_W-1:0] live_cfg;
    logic                 irc_pending;
    lpm_state_t           state;
    logic [31:0]          rdata;

    logic                 next_sleep_bod;
    logic                 next_sleep_wdt;
    logic [LPM_CFG_W-1:0] next_wake_cfg;
    logic [LPM_CFG_W-1:0] next_live_cfg;
    logic                 next_irc_pending;
    lpm_state_t           next_state;
    logic [31:0]          next_rdata;

    logic                 wr_sleep;
    logic                 wr_wake;
    logic                 wr_live;
    logic                 irc_stop_now;

    assign wr_sleep     = i_wr && (i_addr == LPM_SLEEP_ADDR);
    assign wr_wake      = i_wr && (i_addr == LPM_WAKE_ADDR);
    assign wr_live      = i_wr && (i_addr == LPM_LIVE_ADDR);
    assign irc_stop_now = irc_pending && i_irc_stop_point;

    // ==================================================================
    // configuration words
    always_comb begin
        next_sleep_bod = sleep_bod;
        next_sleep_wdt = sleep_wdt;
        next_wake_cfg  = wake_cfg;
        if (!i_nrst) begin
            next_sleep_bod = LPM_SLEEP_BOD_R; // RL4
            next_sleep_wdt = LPM_SLEEP_WDT_R; // RL5
            next_wake_cfg  = LPM_CFG_RESET; // RL9 RL10 RL11
        end else begin
            if (wr_sleep) begin
                next_sleep_bod = i_wdata[LPM_BOD_BIT]; // RL4
                next_sleep_wdt = i_wdata[LPM_WDT_BIT]; // RL5
            end
            if (wr_wake) begin
                // reserved bits stored as written; software keeps their pattern
                next_wake_cfg = i_wdata[LPM_CFG_W-1:0]; // RL9 RL10 RL11
            end
            if (i_wdt_lock) begin
                next_sleep_wdt              = 1'b0; // RL6
                next_wake_cfg[LPM_WDT_BIT]  = 1'b0; // RL7
            end
        end
    end

    // ==================================================================
    // live power control and mode tracking
    always_comb begin
        next_live_cfg    = live_cfg;
        next_irc_pending = irc_pending;
        next_state       = state;
        if (!i_nrst) begin
            next_live_cfg    = LPM_CFG_RESET;
            next_irc_pending = 1'b0;
            next_state       = LPM_RUN;
        end else begin
            case (state)
                LPM_RUN: begin
                    if (i_lowpower_enter) begin
                        next_live_cfg[7:0]         = LPM_ALL_OFF; // RL2
                        next_live_cfg[LPM_BOD_BIT] = sleep_bod; // RL1 RL3
                        next_live_cfg[LPM_WDT_BIT] = sleep_wdt; // RL1 RL3
                        next_irc_pending           = 1'b0;
                        next_state                 = LPM_LOW;
                    end else begin
                        if (irc_stop_now) begin
                            next_live_cfg[LPM_IRC_BIT] = 1'b1; // RL14
                            next_irc_pending           = 1'b0;
                        end
                        if (wr_live) begin
                            next_live_cfg = i_wdata[LPM_CFG_W-1:0]; // RL14
                            if (!i_wdata[LPM_IRC_BIT]) begin
                                next_live_cfg[LPM_IRC_BIT] = 1'b0;
                                next_irc_pending           = 1'b0;
                            end else if (!live_cfg[LPM_IRC_BIT] && !irc_stop_now) begin
                                // oscillator clock must stop cleanly before power goes
                                next_live_cfg[LPM_IRC_BIT] = 1'b0; // RL14
                                next_irc_pending           = 1'b1;
                            end
                        end
                    end
                end
                LPM_LOW: begin
                    if (i_wakeup) begin
                        next_live_cfg[7:0] = wake_cfg[7:0]; // RL8
                        next_state         = LPM_RUN;
                    end
                end
                default: begin
                    next_state = LPM_RUN;
                end
            endcase
            if (i_wdt_lock) begin
                next_live_cfg[LPM_WDT_BIT] = 1'b0; // RL7
            end
        end
    end

    // ==================================================================
    // read port
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_nrst && i_rd) begin
            case (i_addr)
                LPM_SLEEP_ADDR: begin
                    next_rdata[LPM_SLEEP_W-1:0]   = LPM_SLEEP_RSVD;
                    next_rdata[LPM_BOD_BIT]       = sleep_bod;
                    next_rdata[LPM_WDT_BIT]       = sleep_wdt;
                end
                LPM_WAKE_ADDR: begin
                    next_rdata[LPM_CFG_W-1:0] = wake_cfg;
                end
                LPM_LIVE_ADDR: begin
                    next_rdata[LPM_CFG_W-1:0] = live_cfg;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==================================================================
    // registers
    always_ff @(posedge i_mclk) begin
        sleep_bod   <= next_sleep_bod;
        sleep_wdt   <= next_sleep_wdt;
        wake_cfg    <= next_wake_cfg;
        live_cfg    <= next_live_cfg;
        irc_pending <= next_irc_pending;
        state       <= next_state;
        rdata       <= next_rdata;
        o_rdata     <= next_rdata;
        o_power_off <= next_live_cfg[7:0];
        o_low_power <= (next_state == LPM_LOW);
    end

    // ==================================================================
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    logic was_rst;
    always_ff @(posedge i_mclk) begin
        was_rst <= !i_nrst;
    end

    sequence s_enter;
        (state == LPM_RUN) && i_lowpower_enter;
    endsequence

    sequence s_wake;
        (state == LPM_LOW) && i_wakeup;
    endsequence

    sequence s_irc_wait;
        irc_pending && !i_irc_stop_point && !wr_live && !i_lowpower_enter;
    endsequence

    sequence s_live_write;
        (state == LPM_RUN) && wr_live && !i_lowpower_enter && !i_wdt_lock;
    endsequence

    AST_ENTRY_COPY: assert property ( // RL1
        s_enter |=> (o_power_off.brownout_off == $past(sleep_bod)) && o_low_power)
        else $error("sleep brown-out bit not copied on entry");

    AST_FORCED_OFF: assert property ( // RL2
        s_enter |=> o_power_off.system_pll_off && o_power_off.crystal_osc_off
            && o_power_off.converter_off && o_power_off.flash_off
            && o_power_off.internal_osc_off && o_power_off.internal_osc_output_off)
        else $error("analog block left powered in low-power mode");

    AST_KEEP_RUNNING: assert property ( // RL3
        s_enter ##0 (!sleep_wdt && !sleep_bod)
            |=> !o_power_off.watchdog_osc_off && !o_power_off.brownout_off)
        else $error("exempt block powered down despite sleep setting");

    AST_SLEEP_BOD_RESET: assert property ( // RL4
        was_rst |-> sleep_bod && (rdata == 32'h0000_0000))
        else $error("sleep brown-out bit reset value wrong");

    AST_SLEEP_WDT_WRITE: assert property ( // RL5
        (wr_sleep && !i_wdt_lock) ##1 (i_rd && (i_addr == LPM_SLEEP_ADDR))
            |=> o_rdata[LPM_WDT_BIT] == $past(i_wdata[LPM_WDT_BIT], 2))
        else $error("sleep watchdog bit not stored");

    AST_LOCK_SLEEP: assert property ( // RL6
        i_wdt_lock |=> !sleep_wdt && !wake_cfg[LPM_WDT_BIT])
        else $error("watchdog power-down kept under lock");

    AST_LOCK_LIVE: assert property ( // RL7
        i_wdt_lock[*2] |=> !o_power_off.watchdog_osc_off)
        else $error("watchdog oscillator powered down under lock");

    AST_WAKE_APPLY: assert property ( // RL8
        s_wake ##0 !i_wdt_lock |=> (o_power_off == $past(wake_cfg[7:0])) && !o_low_power)
        else $error("wake-up word not applied");

    AST_WAKE_RESET: assert property ( // RL9
        was_rst |-> (wake_cfg == LPM_CFG_RESET) && (live_cfg == LPM_CFG_RESET))
        else $error("wake-up word reset value wrong");

    AST_IRC_WAIT: assert property ( // RL14
        s_irc_wait |=> !o_power_off.internal_osc_off ##0 irc_pending)
        else $error("oscillator powered down before clean stop");

    AST_IRC_STOP: assert property ( // RL14
        (state == LPM_RUN) && irc_pending && i_irc_stop_point && !wr_live
            && !i_lowpower_enter |=> o_power_off.internal_osc_off && !irc_pending)
        else $error("oscillator power-down not taken at stop point");

    AST_ENTRY_WDT: assert property ( // RL1
        s_enter ##0 !i_wdt_lock |=> o_power_off.watchdog_osc_off == $past(sleep_wdt))
        else $error("sleep watchdog bit not copied on entry");

    AST_LOW_HOLD: assert property ( // RL2
        (state == LPM_LOW) && !i_wakeup && !i_wdt_lock |=> $stable(o_power_off))
        else $error("power state changed while in low-power mode");

    AST_ENTRY_CANCEL: assert property ( // RL2
        s_enter |=> !irc_pending)
        else $error("oscillator power-down still pending after entry");

    AST_KEEP_BOD: assert property ( // RL3
        s_enter ##0 !sleep_bod |=> !o_power_off.brownout_off)
        else $error("brown-out detector powered down despite sleep setting");

    AST_SLEEP_BOD_WRITE: assert property ( // RL4
        wr_sleep |=> sleep_bod == $past(i_wdata[LPM_BOD_BIT]))
        else $error("sleep brown-out bit not stored");

    AST_LOCK_WAKE: assert property ( // RL7
        s_wake ##0 i_wdt_lock |=> !o_power_off.watchdog_osc_off && !o_low_power)
        else $error("watchdog oscillator powered down on wake under lock");

    AST_WAKE_WRITE: assert property ( // RL9 RL10 RL11
        wr_wake && !i_wdt_lock |=> wake_cfg == $past(i_wdata[LPM_CFG_W-1:0]))
        else $error("wake-up word not stored");

    AST_LIVE_WRITE: assert property ( // RL14
        s_live_write ##0 !i_wdata[LPM_IRC_BIT] |=> o_power_off == $past(i_wdata[7:0]))
        else $error("live power write not applied at once");

endmodule
